// [rtl/lacf_regs.vh]
// Register offsets, field positions, reset values and timing counts for the light ADC configuration block
`ifndef LACF_REGS_VH
`define LACF_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define LACF_IDX_IR_SEL      8'h0e
`define LACF_IDX_AUX_SEL     8'h0f
`define LACF_IDX_VIS_REC     8'h10
`define LACF_IDX_VIS_GAIN    8'h11
`define LACF_IDX_CTRL        8'h20
`define LACF_IDX_STATUS      8'h21
`define LACF_IDX_REV         8'h22

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LACF_RST_IR_SEL      8'h00
`define LACF_RST_AUX_SEL     8'h65
`define LACF_RST_VIS_REC     8'h70
`define LACF_RST_VIS_GAIN    8'h00

// ----------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------
`define LACF_REC_MSB         6
`define LACF_REC_LSB         4
`define LACF_GAIN_MSB        2
`define LACF_GAIN_LSB        0
`define LACF_MASK_VIS_REC    8'h70
`define LACF_MASK_VIS_GAIN   8'h07

// ----------------------------------------------------------------
// Input select encodings
// ----------------------------------------------------------------
`define LACF_IR_SMALL        8'h00
`define LACF_IR_LARGE        8'h03
`define LACF_AUX_TEMP        8'h65
`define LACF_AUX_VDD         8'h75

// Analog mux codes driven to the front end
`define LACF_MUX_NONE        3'h0
`define LACF_MUX_IR_SMALL    3'h1
`define LACF_MUX_IR_LARGE    3'h2
`define LACF_MUX_TEMP        3'h3
`define LACF_MUX_VDD         3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LACF_CLK_PERIOD_NS   10
`define LACF_ADC_BASE_NS     50
`define LACF_ADC_BASE_CYC    (`LACF_ADC_BASE_NS / `LACF_CLK_PERIOD_NS)

// Measurement kinds requested by the sequencer
`define LACF_KIND_VIS        2'h0
`define LACF_KIND_IR         2'h1
`define LACF_KIND_AUX        2'h2

`endif

// [rtl/lacf_adc_tick.v]
// ADC clock enable divider: base period times two to the gain
`timescale 1ns/10ps
module lacf_adc_tick #(
  parameter BASE_CYC = 5
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Control
  input  wire       run,
  input  wire [2:0] gain,
  // Enable out
  output reg        tick
);

  reg [15:0] cnt;
  wire [15:0] limit;

  // Period in system cycles is BASE_CYC shifted by gain
  assign limit = (BASE_CYC[15:0] << gain) - 16'h0001;

  // Free count while running, one-cycle pulse at wrap
  always @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt  <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// [rtl/lacf_top.v]
// Light ADC input select, recovery and gain configuration with measurement timing
`timescale 1ns/10ps
`include "lacf_regs.vh"
module lacf_top #(
  parameter INTEG_CLKS = 16
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Sequencer request
  input  wire        meas_start,
  input  wire [1:0]  meas_kind,
  // Front end control
  output reg  [2:0]  adc_mux,
  output reg         adc_ref_gnd,
  output reg         adc_recover,
  output reg         adc_integrate,
  output reg         adc_clk_en,
  output reg         meas_done
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0]  ir_ambient_input_select;
  reg [7:0]  auxiliary_input_select;
  reg [7:0]  visible_recovery_period;
  reg [7:0]  visible_integration_gain;
  reg        early_rev;
  reg        sel_error;
  reg        busy;

  wire [7:0] idx;
  wire       bus_req;
  wire       bus_wr;

  assign idx     = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

  // Recovery length in ADC clocks for a code
  function [9:0] rec_clocks;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        rec_clocks = 10'h001;
      end else begin
        rec_clocks = (10'h008 << (code - 3'h1)) - 10'h001;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Register writes, reserved bits masked
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      ir_ambient_input_select  <= `LACF_RST_IR_SEL;
      auxiliary_input_select   <= `LACF_RST_AUX_SEL;
      visible_recovery_period  <= `LACF_RST_VIS_REC;
      visible_integration_gain <= `LACF_RST_VIS_GAIN;
      early_rev                <= 1'b0;
    end else if (bus_wr) begin
      case (idx)
        `LACF_IDX_IR_SEL: begin
          ir_ambient_input_select <= wb_dat_i[7:0];
        end
        `LACF_IDX_AUX_SEL: begin
          auxiliary_input_select <= wb_dat_i[7:0];
        end
        `LACF_IDX_VIS_REC: begin
          visible_recovery_period <= wb_dat_i[7:0] & `LACF_MASK_VIS_REC;
        end
        `LACF_IDX_VIS_GAIN: begin
          visible_integration_gain <= wb_dat_i[7:0] & `LACF_MASK_VIS_GAIN;
        end
        `LACF_IDX_CTRL: begin
          early_rev <= wb_dat_i[0];
        end
        default: begin
          early_rev <= early_rev;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one cycle ack, zero for unmapped
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        case (idx)
          `LACF_IDX_IR_SEL:   wb_dat_o <= {24'h00_0000, ir_ambient_input_select};
          `LACF_IDX_AUX_SEL:  wb_dat_o <= {24'h00_0000, auxiliary_input_select};
          `LACF_IDX_VIS_REC:  wb_dat_o <= {24'h00_0000, visible_recovery_period};
          `LACF_IDX_VIS_GAIN: wb_dat_o <= {24'h00_0000, visible_integration_gain};
          `LACF_IDX_CTRL:     wb_dat_o <= {31'h0000_0000, early_rev};
          `LACF_IDX_STATUS:   wb_dat_o <= {28'h000_0000, sel_error, adc_integrate, adc_recover, busy};
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencing
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_REC   = 2'h1;
  localparam ST_INTEG = 2'h2;

  reg [1:0]  state;
  reg [9:0]  remain;
  reg [2:0]  cur_gain;
  wire       tick;
  reg  [2:0] next_mux;
  reg        next_valid;
  reg        next_timed;

  wire [2:0] rec_code;
  wire [2:0] gain_code;
  assign rec_code  = visible_recovery_period[`LACF_REC_MSB:`LACF_REC_LSB];
  assign gain_code = visible_integration_gain[`LACF_GAIN_MSB:`LACF_GAIN_LSB];

  // Decode the input for a requested kind
  always @* begin
    next_mux   = `LACF_MUX_NONE;
    next_valid = 1'b1;
    next_timed = 1'b0;
    case (meas_kind)
      `LACF_KIND_VIS: begin
        next_timed = 1'b1;
      end
      `LACF_KIND_IR: begin
        next_timed = early_rev;
        if (ir_ambient_input_select == `LACF_IR_SMALL) begin
          next_mux = `LACF_MUX_IR_SMALL;
        end else if (ir_ambient_input_select == `LACF_IR_LARGE) begin
          next_mux = `LACF_MUX_IR_LARGE;
        end else begin
          next_valid = 1'b0;
        end
      end
      `LACF_KIND_AUX: begin
        if (auxiliary_input_select == `LACF_AUX_TEMP) begin
          next_mux = `LACF_MUX_TEMP;
        end else if (auxiliary_input_select == `LACF_AUX_VDD) begin
          next_mux = `LACF_MUX_VDD;
        end else begin
          next_valid = 1'b0;
        end
      end
      default: begin
        next_valid = 1'b0;
      end
    endcase
  end

  // ADC clock enable, slowed by gain when timed by the visible settings
  lacf_adc_tick #(
    .BASE_CYC (`LACF_ADC_BASE_CYC)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (busy),
    .gain    (cur_gain),
    .tick    (tick)
  );

  // Recovery (visible, or IR with early_rev set) then integration, counted in ADC clocks
  always @(posedge clk_sys) begin
    if (rst) begin
      state         <= ST_IDLE;
      remain        <= 10'h000;
      cur_gain      <= 3'h0;
      busy          <= 1'b0;
      adc_mux       <= `LACF_MUX_NONE;
      adc_ref_gnd   <= 1'b0;
      adc_recover   <= 1'b0;
      adc_integrate <= 1'b0;
      adc_clk_en    <= 1'b0;
      meas_done     <= 1'b0;
      sel_error     <= 1'b0;
    end else begin
      meas_done  <= 1'b0;
      adc_clk_en <= tick;
      if (bus_wr && idx == `LACF_IDX_STATUS && wb_dat_i[3]) begin
        sel_error <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (meas_start) begin
            if (!next_valid) begin
              sel_error <= 1'b1;
              meas_done <= 1'b1;
            end else begin
              busy        <= 1'b1;
              adc_mux     <= next_mux;
              adc_ref_gnd <= (meas_kind == `LACF_KIND_AUX);
              cur_gain    <= next_timed ? gain_code : 3'h0;
              if (next_timed) begin
                remain      <= rec_clocks(rec_code);
                adc_recover <= 1'b1;
                state       <= ST_REC;
              end else begin
                remain        <= INTEG_CLKS[9:0];
                adc_integrate <= 1'b1;
                state         <= ST_INTEG;
              end
            end
          end
        end
        ST_REC: begin
          if (tick) begin
            if (remain == 10'h001) begin
              adc_recover   <= 1'b0;
              adc_integrate <= 1'b1;
              remain        <= INTEG_CLKS[9:0];
              state         <= ST_INTEG;
            end else begin
              remain <= remain - 10'h001;
            end
          end
        end
        ST_INTEG: begin
          if (tick) begin
            if (remain == 10'h001) begin
              adc_integrate <= 1'b0;
              adc_ref_gnd   <= 1'b0;
              adc_mux       <= `LACF_MUX_NONE;
              busy          <= 1'b0;
              meas_done     <= 1'b1;
              state         <= ST_IDLE;
            end else begin
              remain <= remain - 10'h001;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Recovery/gain pairing is left to software; nothing checks it

endmodule

// [tb/lacf_top_sva.sv]
// Assertion checker for the light ADC configuration block
`timescale 1ns/10ps
module lacf_chk (
  // Clock and reset
  input wire logic        clk_sys, rst,
  // Wishbone slave
  input wire logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // Sequencer and front end
  input wire logic        meas_start, adc_ref_gnd, adc_recover, adc_integrate, adc_clk_en, meas_done,
  input wire logic [1:0]  meas_kind,
  input wire logic [2:0]  adc_mux
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Bus answer timing and upper read data bits
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_next_edge_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  upper_bits_zero_a: assert property (wb_dat_o[31:8] == 24'h00_0000) else $error("upper read bits set");
  // Measurement sequencing
  done_one_cycle_a: assert property (meas_done |=> !meas_done) else $error("done held too long");
  phase_excl_a: assert property (!(adc_recover && adc_integrate)) else $error("recover and integrate overlap");
  rec_to_integ_a: assert property ($fell(adc_recover) |-> adc_integrate) else $error("no integrate after recovery");
  ref_on_aux_a: assert property (adc_ref_gnd == (adc_mux == 3'h3 || adc_mux == 3'h4)) else $error("aux ref wrong");
  aux_tick_gap_a: assert property (adc_ref_gnd && adc_clk_en |=> !adc_clk_en [*4]) else $error("aux tick early");
  done_idle_a: assert property (meas_done |-> !adc_recover && !adc_integrate) else $error("phase active at done");
endmodule
bind lacf_top lacf_chk lacf_chk_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .meas_start(meas_start), .adc_ref_gnd(adc_ref_gnd), .adc_recover(adc_recover),
  .adc_integrate(adc_integrate), .adc_clk_en(adc_clk_en), .meas_done(meas_done), .meas_kind(meas_kind),
  .adc_mux(adc_mux));

// [tb/tb.sv]
// Register and measurement timing testbench for the light ADC configuration block
`timescale 1ns/10ps
module tb;
  logic        clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, meas_start = 0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0000_0000, wb_dat_o;
  logic [1:0]  meas_kind = 2'h0;
  logic [2:0]  adc_mux;
  logic        wb_ack_o, adc_ref_gnd, adc_recover, adc_integrate, adc_clk_en, meas_done;
  logic [31:0] q;
  int          bad_count = 0, checked = 0;
  int          rec_n[8] = '{1, 7, 15, 31, 63, 127, 255, 511};
  lacf_top #(.INTEG_CLKS(2)) lacf_top_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .meas_start(meas_start), .meas_kind(meas_kind), .adc_mux(adc_mux), .adc_ref_gnd(adc_ref_gnd),
    .adc_recover(adc_recover), .adc_integrate(adc_integrate), .adc_clk_en(adc_clk_en), .meas_done(meas_done));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task wbx(input logic w, input [7:0] idx, input [7:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; dat <= {24'h00_0000, d};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    q = wb_dat_o;
    cyc <= 0; stb <= 0;
  endtask
  // Start one measurement, count ADC ticks and the last tick gap
  task meas(input [1:0] k, input [2:0] xmux, input logic xref, input [31:0] xt, input [31:0] xgap);
    int n, t, last, gap;
    logic [2:0] m;
    logic r;
    n = 0; t = 0; last = 0; gap = 0; m = 3'h7; r = 1'bx;
    @(posedge clk_sys);
    meas_start <= 1; meas_kind <= k;
    @(posedge clk_sys);
    meas_start <= 0;
    while (meas_done !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
      if (adc_clk_en === 1'b1) begin
        t++; gap = n - last; last = n;
        if (meas_done !== 1'b1) begin
          m = adc_mux; r = adc_ref_gnd;
        end
      end
    end
    if (n >= 20000) bad_count++;
    chk(t, xt); chk(gap, xgap); chk({29'h0, m}, {29'h0, xmux}); chk({31'h0, r}, {31'h0, xref});
  endtask
  task tally_and_finish;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    wbx(0, 8'h0e, 8'h00); chk(q, 32'h0000_0000);
    wbx(0, 8'h0f, 8'h00); chk(q, 32'h0000_0065);
    wbx(0, 8'h10, 8'h00); chk(q, 32'h0000_0070);
    wbx(0, 8'h11, 8'h00); chk(q, 32'h0000_0000);
    wbx(0, 8'h30, 8'h00); chk(q, 32'h0000_0000);
    wbx(1, 8'h10, 8'hff); wbx(0, 8'h10, 8'h00); chk(q, 32'h0000_0070);
    wbx(1, 8'h11, 8'hff); wbx(0, 8'h11, 8'h00); chk(q, 32'h0000_0007);
    $display("test registers done");
    wbx(1, 8'h11, 8'h00);
    for (int r = 0; r < 8; r++) begin
      wbx(1, 8'h10, {1'b0, r[2:0], 4'h0}); meas(0, 3'h0, 0, rec_n[r] + 2, 5);
    end
    $display("test recovery codes done");
    wbx(1, 8'h10, 8'h00);
    for (int g = 0; g < 8; g++) begin
      wbx(1, 8'h11, {5'h00, g[2:0]}); meas(0, 3'h0, 0, 3, 5 << g);
    end
    wbx(1, 8'h11, 8'h02); wbx(1, 8'h10, 8'h50); meas(0, 3'h0, 0, 129, 20);
    $display("test gain codes done");
    wbx(1, 8'h0e, 8'h00); meas(1, 3'h1, 0, 2, 5);
    wbx(1, 8'h0e, 8'h03); meas(1, 3'h2, 0, 2, 5);
    wbx(1, 8'h0f, 8'h75); meas(2, 3'h4, 1, 2, 5);
    wbx(1, 8'h0f, 8'h65); meas(2, 3'h3, 1, 2, 5);
    $display("test input selects done");
    wbx(1, 8'h20, 8'h01); wbx(1, 8'h11, 8'h01); wbx(1, 8'h10, 8'h10);
    meas(1, 3'h2, 0, 9, 10);
    $display("test early revision done");
    tally_and_finish;
  end
endmodule
